/* File: logic/tnf_pkg.sv */
`default_nettype none
package tnf_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int          BUF_AW        = 11;
  localparam int          BUF_DEPTH     = 2048;

  // ************************************************************
  // Register map (byte data, low bits of a 3-bit address)
  // ************************************************************
  localparam logic [2:0]  REG_STATUS    = 3'h0;
  localparam logic [2:0]  REG_MASK      = 3'h1;
  localparam logic [2:0]  REG_CONFIG    = 3'h2;
  localparam logic [2:0]  REG_NODE_ID   = 3'h3;
  localparam logic [2:0]  REG_PTR_HI    = 3'h4;
  localparam logic [2:0]  REG_PTR_LO    = 3'h5;
  localparam logic [2:0]  REG_DATA      = 3'h6;

  // ************************************************************
  // Command word fields
  // ************************************************************
  localparam int          CMD_OP_HI     = 2;
  localparam int          CMD_PAGE_LO   = 3;
  localparam int          CMD_PAGE_HI   = 4;
  localparam int          CMD_OFFS_BIT  = 5;
  localparam logic [2:0]  CMD_DISABLE_TX = 3'h1;
  localparam logic [2:0]  CMD_TX_PAGE   = 3'h3;
  localparam logic [2:0]  CMD_RX_PAGE   = 3'h4;

  // ************************************************************
  // Status, config and reset values
  // ************************************************************
  localparam int          ST_TA         = 0;
  localparam int          ST_TMA        = 1;
  localparam int          ST_RI         = 2;
  localparam int          ST_EXCESSIVE_NAK_FLAG     = 3;
  localparam logic [7:0]  IRQ_SOURCES   = 8'h0D;
  localparam int          CFG_LONG_BIT  = 0;
  localparam int          PTR_HI_BITS   = 3;
  localparam logic        TA_RST        = 1'b1;
  localparam logic        RI_RST        = 1'b1;
  localparam logic [7:0]  MASK_RST      = 8'h00;
  localparam logic [7:0]  CONFIG_RST    = 8'h00;
  localparam logic [7:0]  NODE_ID_RST   = 8'h00;

  // ************************************************************
  // Packet layout in a page
  // ************************************************************
  localparam logic [8:0]  PTR_SID       = 9'h000;
  localparam logic [8:0]  PTR_DID       = 9'h001;
  localparam logic [8:0]  PTR_COUNT     = 9'h002;
  localparam logic [8:0]  PTR_LCOUNT    = 9'h003;
  localparam logic [8:0]  PTR_SHORT_END = 9'h0FF;
  localparam logic [8:0]  PTR_LONG_END  = 9'h1FF;
  localparam logic [7:0]  LONG_MARK     = 8'h00;
  localparam logic [7:0]  BROADCAST_ID  = 8'h00;

  typedef enum logic [2:0] {
    TX_IDLE       = 3'b000,
    TX_WAIT_TOKEN = 3'b001,
    TX_FBE        = 3'b010,
    TX_SEND       = 3'b011,
    TX_WAIT_ACK   = 3'b100
  } tnf_tx_state_t;

  function automatic logic [BUF_AW-1:0] tnf_page_base(input logic [1:0] nn, input logic f);
    return {nn, f, 8'h00};
  endfunction

  function automatic logic tnf_long_pkt(input logic long_en, input logic [7:0] count);
    return long_en && (count == LONG_MARK);
  endfunction

  function automatic logic [8:0] tnf_end_ptr(input logic is_long);
    return is_long ? PTR_LONG_END : PTR_SHORT_END;
  endfunction

  // Header bytes first, then jump to where the data begins
  function automatic logic [8:0] tnf_next_ptr(input logic [8:0] ptr, input logic [7:0] data,
                                              input logic long_en, input logic is_long);
    logic [8:0] nxt;
    nxt = ptr + 9'h001;
    if (ptr == PTR_COUNT) begin
      nxt = tnf_long_pkt(long_en, data) ? PTR_LCOUNT : {1'b0, data};
    end else if (ptr == PTR_LCOUNT && is_long) begin
      // Long count is the offset of the first data byte, so data ends at 511
      nxt = {1'b0, data};
    end
    return nxt;
  endfunction

endpackage
`default_nettype wire

/* File: logic/tnf_buffer_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module tnf_buffer_ram #(
  parameter int AW    = 11,
  parameter int DEPTH = 2048
) (
  input  wire logic          clock,
  input  wire logic          host_we,
  input  wire logic [AW-1:0] host_addr,
  input  wire logic [7:0]    host_wdata,
  output logic      [7:0]    host_rdata,
  input  wire logic          eng_we,
  input  wire logic [AW-1:0] eng_waddr,
  input  wire logic [7:0]    eng_wdata,
  input  wire logic [AW-1:0] eng_raddr,
  output logic      [7:0]    eng_rdata
);

  logic [7:0] mem [DEPTH];

  // Engine write wins a same-address collision: network data must not be lost
  always_ff @(posedge clock) begin
    if (eng_we) begin
      mem[eng_waddr] <= eng_wdata;
    end
    if (host_we && !(eng_we && eng_waddr == host_addr)) begin
      mem[host_addr] <= host_wdata;
    end
  end

  assign host_rdata = mem[host_addr];
  assign eng_rdata  = mem[eng_raddr];

endmodule
`default_nettype wire

/* File: logic/tnf_sequencer.sv */
//Contract
// R1: Page byte 0 holds source node ident, byte 1 destination node ident.
// R2: With long packets enabled, byte 2 zero means long, non-zero means short.
// R3: Short packet byte 2 holds 256 minus data byte count.
// R4: Long packet byte 2 is zero, byte 3 holds 512 minus count.
// R5: Transmitter substitutes local node ident for the source byte.
// R6: Host keeps short packets 1..253 bytes, long 257..508 bytes.
// R7: Host pads 254..256 byte messages into long packets.
// R8: Host waits for transmitter available before a transmit command.
// R9: Accepted transmit command clears available and acknowledged flags.
// R10: Transmit conclusion interrupts only when its mask bit allows.
// R11: Non-broadcast sends a free buffer enquiry before any data.
// R12: After enquiry ack send packet; packet ack sets both flags.
// R13: Enquiry nak passes token and repeats enquiry at next token.
// R14: Too many enquiry naks set excessive nak flag, maskable interrupt.
// R15: Cancel abandons transmit at next token: available 1, acknowledged 0.
// R16: No enquiry response sets available, leaves acknowledged clear.
// R17: Noise answer to enquiry does not pass the token.
// R18: Receiver answers enquiry with nak while inhibited.
// R19: Receiver inhibited interrupts only when its mask bit is set.
// R20: Receive command clears inhibited flag and selects target page.
// R21: Received bytes are stored in the sender's layout.
// R22: Inhibited flag sets once a packet is completely and correctly stored.
// R23: Page start is page number times 512 plus 256 with offset bit.
// R24: Broadcast skips the enquiry and sends at next token.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tnf_sequencer
  import tnf_pkg::*;
#(
  parameter int NAK_LIMIT = 128,
  parameter int NAK_W     = 8
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       token_in,
  input  wire logic       resp_ack,
  input  wire logic       resp_nak,
  input  wire logic       resp_none,
  input  wire logic       resp_noise,
  output logic            fbe_send,
  output logic      [7:0] fbe_dest,
  output logic            token_pass,
  output logic            tx_valid,
  output logic      [7:0] tx_data,
  output logic            tx_last,
  input  wire logic       tx_ready,
  input  wire logic       fbe_in,
  output logic            fbe_reply_ack,
  output logic            fbe_reply_nak,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_end,
  input  wire logic       rx_good,
  output logic            irq
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0]        mask;
  logic [7:0]        config_reg;
  logic [7:0]        node_id;
  logic [7:0]        status;
  logic              transmitter_available_flag;
  logic              transmit_acknowledged_flag;
  logic              receiver_inhibited_flag;
  logic              excessive_nak_flag;
  logic [BUF_AW-1:0] host_ptr;
  logic [7:0]        host_rdata;
  tnf_tx_state_t     tx_state;
  logic [BUF_AW-1:0] tx_base;
  logic [BUF_AW-1:0] rx_base;
  logic [8:0]        tx_ptr;
  logic [8:0]        rx_ptr;
  logic              tx_long;
  logic              rx_long;
  logic              rx_full;
  logic              rx_seen;
  logic              is_bcast;
  logic              cancel_pend;
  logic [NAK_W-1:0]  nak_count;
  logic [BUF_AW-1:0] eng_raddr;
  logic [BUF_AW-1:0] eng_waddr;
  logic [7:0]        eng_rdata;
  logic              long_en;
  logic              cmd_wr;
  logic [2:0]        cmd_op;
  logic [BUF_AW-1:0] cmd_base;
  logic              tx_cmd;
  logic              arm_receive_to_page_cmd;
  logic              dis_cmd;
  logic              host_we;
  logic              tx_load;
  logic              tx_fin;
  logic              rx_wr;
  logic              token_here;
  logic              nak_limit_hit;

  // ************************************************************
  // Command decode
  // ************************************************************
  assign long_en  = config_reg[CFG_LONG_BIT];
  assign cmd_wr   = reg_wr && (reg_addr == REG_STATUS);
  assign cmd_op   = reg_wdata[CMD_OP_HI:0];
  assign cmd_base = tnf_page_base(reg_wdata[CMD_PAGE_HI:CMD_PAGE_LO],
                                  reg_wdata[CMD_OFFS_BIT]); // R23
  // A transmit command while the previous one is still running is ignored
  assign tx_cmd   = cmd_wr && (cmd_op == CMD_TX_PAGE) && transmitter_available_flag; // R8
  assign arm_receive_to_page_cmd = cmd_wr && (cmd_op == CMD_RX_PAGE);
  assign dis_cmd  = cmd_wr && (cmd_op == CMD_DISABLE_TX);
  assign host_we  = reg_wr && (reg_addr == REG_DATA);

  always_comb begin
    status             = 8'h00;
    status[ST_TA]      = transmitter_available_flag;
    status[ST_TMA]     = transmit_acknowledged_flag;
    status[ST_RI]      = receiver_inhibited_flag;
    status[ST_EXCESSIVE_NAK_FLAG]  = excessive_nak_flag;
  end

  // ************************************************************
  // Register file
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      mask       <= MASK_RST;
      config_reg <= CONFIG_RST;
      node_id    <= NODE_ID_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_MASK) begin
        mask <= reg_wdata;
      end else if (reg_addr == REG_CONFIG) begin
        config_reg <= reg_wdata;
      end else if (reg_addr == REG_NODE_ID) begin
        node_id <= reg_wdata;
      end
    end
  end

  // Writing the low byte completes the pointer; data access auto-increments
  always_ff @(posedge clock) begin
    if (rst) begin
      host_ptr <= '0;
    end else if (reg_wr && reg_addr == REG_PTR_HI) begin
      host_ptr[BUF_AW-1:8] <= reg_wdata[PTR_HI_BITS-1:0];
    end else if (reg_wr && reg_addr == REG_PTR_LO) begin
      host_ptr[7:0] <= reg_wdata;
    end else if ((reg_wr || reg_rd) && reg_addr == REG_DATA) begin
      host_ptr <= host_ptr + BUF_AW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == REG_STATUS) begin
        reg_rdata <= status;
      end else if (reg_addr == REG_MASK) begin
        reg_rdata <= mask;
      end else if (reg_addr == REG_CONFIG) begin
        reg_rdata <= config_reg;
      end else if (reg_addr == REG_NODE_ID) begin
        reg_rdata <= node_id;
      end else if (reg_addr == REG_PTR_HI) begin
        reg_rdata <= {5'h00, host_ptr[BUF_AW-1:8]};
      end else if (reg_addr == REG_PTR_LO) begin
        reg_rdata <= host_ptr[7:0];
      end else if (reg_addr == REG_DATA) begin
        reg_rdata <= host_rdata;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Level interrupt follows the flags; acknowledged flag never interrupts
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask & IRQ_SOURCES); // R10 R14 R19
    end
  end

  // ************************************************************
  // Transmit sequencer
  // ************************************************************
  assign token_here    = (tx_state == TX_WAIT_TOKEN) && token_in;
  assign nak_limit_hit = (nak_count == NAK_W'(NAK_LIMIT - 1));
  assign tx_load       = (tx_state == TX_SEND) && (!tx_valid || (tx_ready && !tx_last));
  assign tx_fin        = (tx_state == TX_SEND) && tx_valid && tx_ready && tx_last;
  assign eng_raddr     = tx_base + {2'b00, tx_ptr};

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_state                   <= TX_IDLE;
      transmitter_available_flag <= TA_RST;
      transmit_acknowledged_flag <= 1'b0;
      tx_base                    <= '0;
      token_pass                 <= 1'b0;
      fbe_send                   <= 1'b0;
      fbe_dest                   <= 8'h00;
      is_bcast                   <= 1'b0;
      nak_count                  <= '0;
    end else begin
      token_pass <= 1'b0;
      fbe_send   <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (tx_cmd) begin
            transmitter_available_flag <= 1'b0; // R9
            transmit_acknowledged_flag <= 1'b0; // R9
            tx_base                    <= cmd_base; // R23
            nak_count                  <= '0;
            tx_state                   <= TX_WAIT_TOKEN;
          end
        end
        TX_WAIT_TOKEN: begin
          if (token_in) begin
            if (cancel_pend) begin
              transmitter_available_flag <= 1'b1; // R15
              token_pass                 <= 1'b1;
              tx_state                   <= TX_IDLE;
            end else if (eng_rdata == BROADCAST_ID) begin
              is_bcast <= 1'b1; // R24
              tx_state <= TX_SEND;
            end else begin
              is_bcast <= 1'b0;
              fbe_send <= 1'b1; // R11
              fbe_dest <= eng_rdata;
              tx_state <= TX_FBE;
            end
          end
        end
        TX_FBE: begin
          if (resp_ack) begin
            tx_state <= TX_SEND; // R12
          end else if (resp_nak) begin
            token_pass <= 1'b1; // R13
            if (!nak_limit_hit) begin
              nak_count <= nak_count + NAK_W'(1);
            end
            tx_state <= TX_WAIT_TOKEN; // R13
          end else if (resp_none) begin
            transmitter_available_flag <= 1'b1; // R16
            token_pass                 <= 1'b1;
            tx_state                   <= TX_IDLE;
          end else if (resp_noise) begin
            // Token is kept; the ring recovers by reconfiguration
            tx_state <= TX_WAIT_TOKEN; // R17
          end
        end
        TX_SEND: begin
          if (tx_fin) begin
            if (is_bcast) begin
              transmitter_available_flag <= 1'b1;
              token_pass                 <= 1'b1;
              tx_state                   <= TX_IDLE;
            end else begin
              tx_state <= TX_WAIT_ACK;
            end
          end
        end
        TX_WAIT_ACK: begin
          if (resp_ack) begin
            transmitter_available_flag <= 1'b1; // R12
            transmit_acknowledged_flag <= 1'b1; // R12
            token_pass                 <= 1'b1;
            tx_state                   <= TX_IDLE;
          end else if (resp_nak || resp_none || resp_noise) begin
            transmitter_available_flag <= 1'b1;
            token_pass                 <= 1'b1;
            tx_state                   <= TX_IDLE;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // Set by the sequencer wins over a clearing command in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      excessive_nak_flag <= 1'b0;
    end else if (tx_state == TX_FBE && resp_nak && nak_limit_hit) begin
      excessive_nak_flag <= 1'b1; // R14
    end else if (tx_cmd || dis_cmd) begin
      excessive_nak_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cancel_pend <= 1'b0;
    end else if (dis_cmd && tx_state != TX_IDLE) begin
      cancel_pend <= 1'b1; // R15
    end else if (token_here || tx_cmd) begin
      cancel_pend <= 1'b0;
    end
  end

  // Byte stream: source ident replaced, then header, then data to page end
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      tx_ptr   <= PTR_SID;
      tx_long  <= 1'b0;
    end else if (tx_cmd) begin
      tx_ptr <= PTR_DID; // R1
    end else if ((token_here && !cancel_pend && eng_rdata == BROADCAST_ID)
                 || (tx_state == TX_FBE && resp_ack)) begin
      tx_ptr <= PTR_SID;
    end else if (tx_load) begin
      tx_valid <= 1'b1;
      tx_data  <= (tx_ptr == PTR_SID) ? node_id : eng_rdata; // R5
      tx_last  <= (tx_ptr == tnf_end_ptr(tx_long));
      tx_ptr   <= tnf_next_ptr(tx_ptr, eng_rdata, long_en, tx_long); // R3 R4
      if (tx_ptr == PTR_COUNT) begin
        tx_long <= tnf_long_pkt(long_en, eng_rdata); // R2
      end
    end else if (tx_fin) begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
  end

  // ************************************************************
  // Receive side
  // ************************************************************
  assign rx_wr     = rx_valid && !receiver_inhibited_flag && !rx_full;
  assign eng_waddr = rx_base + {2'b00, rx_ptr};

  always_ff @(posedge clock) begin
    if (rst) begin
      fbe_reply_ack <= 1'b0;
      fbe_reply_nak <= 1'b0;
    end else begin
      fbe_reply_ack <= fbe_in && !receiver_inhibited_flag;
      fbe_reply_nak <= fbe_in && receiver_inhibited_flag; // R18
    end
  end

  // Page bounds are not checked beyond the packet's own end address
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_base <= '0;
      rx_ptr  <= PTR_SID;
      rx_long <= 1'b0;
      rx_full <= 1'b0;
      rx_seen <= 1'b0;
    end else if (arm_receive_to_page_cmd) begin
      rx_base <= cmd_base; // R20 R23
      rx_ptr  <= PTR_SID;
      rx_full <= 1'b0;
      rx_seen <= 1'b0;
    end else if (rx_end) begin
      rx_ptr  <= PTR_SID;
      rx_full <= 1'b0;
      rx_seen <= 1'b0;
    end else if (rx_wr) begin
      rx_ptr  <= tnf_next_ptr(rx_ptr, rx_data, long_en, rx_long); // R21
      rx_full <= (rx_ptr == tnf_end_ptr(rx_long));
      rx_seen <= 1'b1;
      if (rx_ptr == PTR_COUNT) begin
        rx_long <= tnf_long_pkt(long_en, rx_data); // R2
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      receiver_inhibited_flag <= RI_RST;
    end else if (rx_end && rx_good && rx_seen && !receiver_inhibited_flag) begin
      receiver_inhibited_flag <= 1'b1; // R22
    end else if (arm_receive_to_page_cmd) begin
      receiver_inhibited_flag <= 1'b0; // R20
    end
  end

  tnf_buffer_ram #(
    .AW    (BUF_AW),
    .DEPTH (BUF_DEPTH)
  ) u_ram (
    .clock      (clock),
    .host_we    (host_we),
    .host_addr  (host_ptr),
    .host_wdata (reg_wdata),
    .host_rdata (host_rdata),
    .eng_we     (rx_wr),
    .eng_waddr  (eng_waddr),
    .eng_wdata  (rx_data),
    .eng_raddr  (eng_raddr),
    .eng_rdata  (eng_rdata)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence enquiry_s;
    token_here && !cancel_pend && eng_rdata != BROADCAST_ID;
  endsequence
  sequence fbe_nak_s;
    tx_state == TX_FBE && resp_nak;
  endsequence

  tx_accept_clear_a: assert property (tx_cmd |=> !transmitter_available_flag
    && !transmit_acknowledged_flag && tx_state == TX_WAIT_TOKEN) // R9
    else $error("transmit command did not clear flags");
  enquiry_first_a: assert property (enquiry_s |=> fbe_send && !tx_valid
    ##1 !tx_valid) // R11
    else $error("data sent before enquiry answer");
  pkt_ack_flags_a: assert property (tx_state == TX_WAIT_ACK && resp_ack
    |=> transmitter_available_flag && transmit_acknowledged_flag) // R12
    else $error("packet ack did not set both flags");
  nak_retry_a: assert property (fbe_nak_s |=> token_pass && tx_state == TX_WAIT_TOKEN
    && !transmitter_available_flag) // R13
    else $error("enquiry nak did not pass token and wait");
  excess_nak_a: assert property (fbe_nak_s ##0 nak_limit_hit |=> excessive_nak_flag) // R14
    else $error("excessive nak flag not set");
  cancel_done_a: assert property (token_here && cancel_pend |=> transmitter_available_flag
    && !transmit_acknowledged_flag && token_pass) // R15
    else $error("cancel did not conclude transmit");
  no_resp_a: assert property (tx_state == TX_FBE && !resp_ack && !resp_nak && resp_none
    |=> transmitter_available_flag && !transmit_acknowledged_flag) // R16
    else $error("no response handled wrongly");
  noise_keep_a: assert property (tx_state == TX_FBE && resp_noise && !resp_ack && !resp_nak
    && !resp_none |=> !token_pass) // R17
    else $error("token passed after noise");
  inhibit_nak_a: assert property (fbe_in && receiver_inhibited_flag
    |=> fbe_reply_nak && !fbe_reply_ack) // R18
    else $error("inhibited receiver did not nak");
  arm_clear_a: assert property (arm_receive_to_page_cmd && !rx_end
    |=> !receiver_inhibited_flag && rx_base == $past(cmd_base)) // R20
    else $error("receive command did not arm page");
  source_ident_a: assert property (tx_load && tx_ptr == PTR_SID
    |=> tx_valid && tx_data == $past(node_id)) // R5
    else $error("source ident not inserted");
  ri_irq_a: assert property (receiver_inhibited_flag && mask[ST_RI] ##1
    receiver_inhibited_flag && mask[ST_RI] |-> irq) // R19
    else $error("masked-in inhibit did not interrupt");

endmodule
`default_nettype wire

/* File: test/tnf_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tnf_link_model (
  input  wire logic       clock,
  input  wire logic       fbe_send,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            token_in,
  output logic      [3:0] resp,
  output logic            fbe_in,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_end
);
  logic [3:0] fbe_ans = 4'h1;
  logic [7:0] cap[$];
  int         fbes = 0;
  initial {tx_ready, token_in, resp, fbe_in, rx_valid, rx_data, rx_end} = '0;
  // Ready toggles so that every byte meets a stall
  always @(posedge clock) begin
    tx_ready <= ~tx_ready;
    resp <= 4'h0;
    if (fbe_send === 1'b1) begin
      fbes++;
      resp <= fbe_ans;
    end
    if (tx_valid && tx_ready) cap.push_back(tx_data);
    if (tx_valid && tx_ready && tx_last) resp <= 4'h1;
  end
  task automatic token;
    @(posedge clock) token_in <= 1'b1;
    @(posedge clock) token_in <= 1'b0;
  endtask
  task automatic fbe;
    @(posedge clock) fbe_in <= 1'b1;
    @(posedge clock) fbe_in <= 1'b0;
  endtask
  // Data line shows the inverse of the last byte during the end strobe
  task automatic rx_pkt(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge clock);
    {rx_valid, rx_end} <= 2'b01;
    rx_data <= ~rx_data;
    @(posedge clock) rx_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tnf_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata, fbe_dest, tx_data, rx_data;
  logic [3:0] resp;
  logic       fbe_send, token_pass, tx_valid, tx_last, tx_ready, token_in;
  logic       fbe_in, fbe_reply_ack, fbe_reply_nak, rx_valid, rx_end, irq;
  logic       rx_good = 1'b1;
  logic [7:0] lq[$];
  int         error_cnt = 0;
  int         checks = 0;
  int         passes = 0;
  logic [7:0] exp_tx[6] = '{8'h5A, 8'h22, 8'hFD, 8'hA1, 8'hA2, 8'hA3};
  tnf_sequencer #(.NAK_LIMIT(4)) i_tnf_sequencer (.clock, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .token_in, .resp_ack(resp[0]), .resp_nak(resp[1]),
    .resp_none(resp[2]), .resp_noise(resp[3]), .fbe_send, .fbe_dest, .token_pass,
    .tx_valid, .tx_data, .tx_last, .tx_ready, .fbe_in, .fbe_reply_ack, .fbe_reply_nak,
    .rx_valid, .rx_data, .rx_end, .rx_good, .irq);
  tnf_link_model i_tnf_link_model (.clock, .fbe_send, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .token_in, .resp, .fbe_in, .rx_valid, .rx_data, .rx_end);
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) if (token_pass === 1'b1) passes++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clock) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // Bounded wait: a noise answer to the enquiry never passes the token
  task automatic go(input logic [3:0] ans);
    i_tnf_link_model.fbe_ans = ans;
    i_tnf_link_model.token();
    for (int i = 0; i < 60 && token_pass !== 1'b1; i++) @(posedge clock) #1;
    repeat (2) @(posedge clock);
  endtask
  task automatic results;
    $display("Errors %0d, checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    results();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(REG_STATUS, 8'h05);
    wr(REG_NODE_ID, 8'h5A);
    wr(REG_PTR_HI, 8'h02);
    wr(REG_PTR_LO, 8'h01);
    wr(REG_DATA, 8'h22);
    wr(REG_DATA, 8'hFD);
    wr(REG_PTR_LO, 8'hFD);
    for (int i = 3; i < 6; i++) wr(REG_DATA, exp_tx[i]);
    wr(REG_STATUS, 8'h0B);
    rd(REG_STATUS, 8'h04);
    go(4'h1);
    chk(fbe_dest, 8'h22);
    foreach (exp_tx[i]) chk(i_tnf_link_model.cap[i], exp_tx[i]);
    rd(REG_STATUS, 8'h07);
    chk({7'h0, irq}, 8'h00);
    wr(REG_STATUS, 8'h0B);
    repeat (4) go(4'h2);
    chk(i_tnf_link_model.fbes[7:0], 8'h05);
    rd(REG_STATUS, 8'h0C);
    wr(REG_STATUS, 8'h01);
    go(4'h2);
    rd(REG_STATUS, 8'h05);
    wr(REG_STATUS, 8'h0B);
    go(4'h4);
    rd(REG_STATUS, 8'h05);
    wr(REG_STATUS, 8'h0B);
    go(4'h8);
    chk(passes[7:0], 8'h07);
    wr(REG_STATUS, 8'h01);
    go(4'h1);
    wr(REG_PTR_HI, 8'h02);
    wr(REG_PTR_LO, 8'h01);
    wr(REG_DATA, 8'h00);
    wr(REG_STATUS, 8'h0B);
    go(4'h1);
    rd(REG_STATUS, 8'h05);
    chk(i_tnf_link_model.fbes[7:0], 8'h07);
    wr(REG_MASK, 8'h04);
    wr(REG_STATUS, 8'h34);
    rd(REG_STATUS, 8'h01);
    chk({7'h0, irq}, 8'h00);
    i_tnf_link_model.fbe();
    #1 chk({6'h0, fbe_reply_ack, fbe_reply_nak}, 8'h02);
    i_tnf_link_model.rx_pkt({8'h11, 8'h22, 8'hFE, 8'hAA, 8'hBB});
    rd(REG_STATUS, 8'h05);
    chk({7'h0, irq}, 8'h01);
    wr(REG_PTR_HI, 8'h05);
    wr(REG_PTR_LO, 8'h00);
    rd(REG_DATA, 8'h11);
    rd(REG_DATA, 8'h22);
    rd(REG_DATA, 8'hFE);
    wr(REG_PTR_LO, 8'hFE);
    rd(REG_DATA, 8'hAA);
    rd(REG_DATA, 8'hBB);
    i_tnf_link_model.fbe();
    #1 chk({6'h0, fbe_reply_ack, fbe_reply_nak}, 8'h01);
    wr(REG_CONFIG, 8'h01);
    wr(REG_STATUS, 8'h34);
    rx_good <= 1'b0;
    i_tnf_link_model.rx_pkt({8'h11, 8'h22, 8'hFE, 8'hAA, 8'hBB});
    rd(REG_STATUS, 8'h01);
    rx_good <= 1'b1;
    lq = {8'h11, 8'h22, 8'h00, 8'hFF};
    repeat (257) lq.push_back(8'h33);
    i_tnf_link_model.rx_pkt(lq);
    rd(REG_STATUS, 8'h05);
    wr(REG_PTR_HI, 8'h05);
    wr(REG_PTR_LO, 8'hFF);
    rd(REG_DATA, 8'h33);
    results();
  end
endmodule
`default_nettype wire
